// ### design/fsr_pkg.sv
package fsr_pkg;
	// =========================================
	// register addresses (7-bit)
	localparam logic [6:0] ADDR_THERMAL_STATUS = 7'h42;
	localparam logic [6:0] ADDR_DEVICE_STATUS  = 7'h43;
	localparam logic [6:0] ADDR_BUS_FAULT      = 7'h44;
	// =========================================
	// reset values
	localparam logic [7:0] THERMAL_RESET  = 8'h00;
	localparam logic [7:0] DEVICE_RESET   = 8'h00;
	localparam logic [7:0] BUS_RESET      = 8'h00;
	// =========================================
	// field positions
	localparam int PREWARN_BIT  = 0;
	localparam int SHUTDOWN1_BIT = 1;
	localparam int SHUTDOWN2_BIT = 2;
	localparam int FAIL_BIT     = 0;
	localparam int BADCMD_BIT   = 1;
	localparam int WDCNT_LO     = 2;
	localparam int PRIOR_LO     = 6;
	localparam int SUPPLY_LOW_BIT = 0;
	localparam int CANF_LO      = 1;
	localparam int LINF_LO      = 5;
	// =========================================
	// prior-state codes
	localparam logic [1:0] PRIOR_CLEARED = 2'h0;
	localparam logic [1:0] PRIOR_FAILURE = 2'h1;
	localparam logic [1:0] PRIOR_SLEEP   = 2'h2;
	// =========================================
	// clearable masks
	localparam logic [7:0] THERMAL_RC_MASK = 8'h07;
	localparam logic [7:0] DEVICE_RC_MASK  = 8'hC3;
	localparam logic [7:0] BUS_RC_MASK     = 8'h67;
	// =========================================
	// serial frame
	localparam int FRAME_BITS = 16;
	localparam int CLEAR_BIT  = 7;
endpackage

// ### design/fsr_fault_status.sv
`timescale 1ns/1ns
module fsr_fault_status
	import fsr_pkg::*;
#(
	parameter int CFG_W = 3
)(
	input  wire logic             ref_clk,          // logic clock, 100 MHz
	input  wire logic             rst,              // power-on / soft reset
	input  wire logic             spi_valid,        // one-cycle frame strobe
	input  wire logic [15:0]      spi_frame,        // received 16-bit frame
	input  wire logic             spi_frame_bad,    // frame judged invalid
	input  wire logic             restart_pulse,    // entering restart mode
	input  wire logic             thermal_shutdown_second_flag_event,       // second thermal shutdown
	input  wire logic             thermal_shutdown_first_flag_event,       // first thermal shutdown
	input  wire logic             tpw_event,        // thermal prewarning
	input  wire logic             watchdog_failure_count_event,    // watchdog trigger failure
	input  wire logic             wd_trigger_ok,    // successful watchdog trigger
	input  wire logic             wd_stopped,       // watchdog stopped
	input  wire logic             wd_stop_by_fail,  // mode reached by watchdog fail
	input  wire logic [CFG_W-1:0] cfg_select,       // configuration 0..4
	input  wire logic             uv_event,         // main_supply_undervoltage
	input  wire logic             ov_event,         // main supply overvoltage
	input  wire logic             overvoltage_reset_select, // ov counts as failure
	input  wire logic             failsafe_wake,    // wake from failsafe
	input  wire logic             illegal_sleep,    // bad sleep request
	input  wire logic             sleep_exit,       // restart from sleep
	input  wire logic             sleep_wake_pend,  // sleep tried with wake flags
	input  wire logic             lin_tsd,          // lin thermal shutdown
	input  wire logic             lin_txd_dom,      // lin txd dominant timeout
	input  wire logic             lin_bus_dom,      // lin bus dominant timeout
	input  wire logic             can_tsd,          // can thermal shutdown
	input  wire logic             can_txd_dom,      // can txd dominant timeout
	input  wire logic             can_bus_dom,      // can bus dominant timeout
	input  wire logic             can_mode_hi,      // transceiver mode high bit
	input  wire logic             can_supply_low,   // can supply comparator
	output logic                  rd_valid,         // read data strobe
	output logic [7:0]            rd_data,          // register contents
	output logic                  failsafe_req,     // force fail-safe mode
	output logic                  fail_output_pin,  // fail output active
	output logic                  can_tx_disable    // can transmitter off
);
	// =========================================
	// elaboration check
	initial
	begin
		if (CFG_W < 3)
			$error("cfg_select too narrow");
		// configuration codes only reach 4; a very wide select
		// would only hide a wiring mistake at the instance
		if (CFG_W > 8)
			$error("cfg_select too wide");
	end

	// =========================================
	// input synchronisers (analog and pin sources)
	localparam int NS = 11;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	always_ff @(posedge ref_clk)
	begin
		s1_r <= {thermal_shutdown_second_flag_event, thermal_shutdown_first_flag_event, tpw_event, lin_tsd, lin_txd_dom, lin_bus_dom,
			can_tsd, can_txd_dom, can_bus_dom, can_supply_low, uv_event};
		s2_r <= s1_r;
	end
	logic thermal_shutdown_second_flag_s, thermal_shutdown_first_flag_s, tpw_s, lin_tsd_s, lin_txd_s, lin_bus_s;
	logic can_tsd_s, can_txd_s, can_bus_s, vcan_low_s, uv_s;
	assign {thermal_shutdown_second_flag_s, thermal_shutdown_first_flag_s, tpw_s, lin_tsd_s, lin_txd_s, lin_bus_s,
		can_tsd_s, can_txd_s, can_bus_s, vcan_low_s, uv_s} = s2_r;

	// =========================================
	// frame decode
	// address and mode
	logic [6:0] f_addr;
	logic       f_clear;
	assign f_addr  = spi_frame[6:0];
	assign f_clear = spi_frame[CLEAR_BIT];

	function automatic logic clr_hit(input logic [6:0] a);
		clr_hit = spi_valid && !spi_frame_bad && f_clear && (f_addr == a);
	endfunction

	logic clr_therm, clr_dev, clr_bus;
	assign clr_therm = clr_hit(ADDR_THERMAL_STATUS);
	assign clr_dev   = clr_hit(ADDR_DEVICE_STATUS);
	assign clr_bus   = clr_hit(ADDR_BUS_FAULT);

	// sticky update: set wins over clear
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	// =========================================
	// thermal status
	logic [2:0] therm_r;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			therm_r <= THERMAL_RESET[2:0];
		else
		begin
			therm_r[SHUTDOWN2_BIT] <= sticky(therm_r[SHUTDOWN2_BIT], thermal_shutdown_second_flag_s, clr_therm);
			therm_r[SHUTDOWN1_BIT] <= sticky(therm_r[SHUTDOWN1_BIT], thermal_shutdown_first_flag_s, clr_therm);
			therm_r[PREWARN_BIT]   <= sticky(therm_r[PREWARN_BIT], tpw_s, clr_therm);
			// flags survive restart, no auto clear
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			failsafe_req <= 1'b0;
		else
			failsafe_req <= thermal_shutdown_second_flag_s;
	end

	// =========================================
	// watchdog failure count
	// the increment stops at the fail-output threshold, so the
	// reserved count 11 can never be produced here
	// a trigger and a failure in one cycle: the automatic clear wins,
	// since the count must restart from zero after a good trigger
	logic [1:0] wd_cnt_r;
	logic [1:0] wd_cnt_nxt;
	logic       frozen_r;
	logic       cfg_frz;
	logic [1:0] fo_level;
	assign cfg_frz  = (cfg_select == 3'd2) || (cfg_select == 3'd4);
	// threshold: one failure in config 2, two otherwise
	assign fo_level = (cfg_select == 3'd2) ? 2'h1 : 2'h2;

	always_comb
	begin
		wd_cnt_nxt = wd_cnt_r;
		if (wd_trigger_ok || (wd_stopped && !wd_stop_by_fail))
			wd_cnt_nxt = 2'h0;
		else if (watchdog_failure_count_event && !frozen_r && wd_cnt_r < fo_level)
			wd_cnt_nxt = wd_cnt_r + 2'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wd_cnt_r <= 2'h0;
			frozen_r <= 1'b0;
		end
		else
		begin
			wd_cnt_r <= wd_cnt_nxt;
			if (wd_trigger_ok)
				frozen_r <= 1'b0;
			else if (watchdog_failure_count_event && cfg_frz)
				frozen_r <= 1'b1;
		end
	end

	// fail output activation
	logic fo_fire;
	// config zero never fires on first failure
	assign fo_fire = (wd_cnt_nxt == fo_level) && (wd_cnt_r != fo_level)
		&& !(cfg_select == 3'd0 && wd_cnt_nxt == 2'h1);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			fail_output_pin <= 1'b0;
		else if (fo_fire)
			fail_output_pin <= 1'b1;
		else if (wd_trigger_ok)
			fail_output_pin <= 1'b0;
	end

	// =========================================
	// device status flags
	logic [1:0] prior_state_code;
	logic       bad_cmd_r;
	logic       fail_flag_r;
	logic       fail_cause;
	assign fail_cause = (watchdog_failure_count_event && wd_cnt_nxt == fo_level) || thermal_shutdown_second_flag_s || uv_s
		|| (ov_event && overvoltage_reset_select);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			prior_state_code <= DEVICE_RESET[7:6];
		else if (fail_cause || failsafe_wake || illegal_sleep)
			prior_state_code <= PRIOR_FAILURE;
		else if (sleep_exit || sleep_wake_pend)
			prior_state_code <= PRIOR_SLEEP;
		else if (clr_dev)
			prior_state_code <= PRIOR_CLEARED;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			bad_cmd_r   <= DEVICE_RESET[BADCMD_BIT];
			fail_flag_r <= DEVICE_RESET[FAIL_BIT];
		end
		else
		begin
			bad_cmd_r   <= sticky(bad_cmd_r, spi_valid && spi_frame_bad, clr_dev);
			fail_flag_r <= sticky(fail_flag_r, fo_fire, clr_dev);
		end
	end

	// =========================================
	// bus fault status
	logic [1:0] lin_fault_code;
	logic [1:0] can_fault_code;
	logic       bus_supply_low_flag;
	logic       vcan_check;

	// encode fault cause into code, higher code wins
	function automatic logic [1:0] fcode(input logic tsd, input logic txd, input logic bus);
		fcode = bus ? 2'h3 : txd ? 2'h2 : tsd ? 2'h1 : 2'h0;
	endfunction

	// comparator enabled in can normal or receive
	assign vcan_check = vcan_low_s && can_mode_hi;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			lin_fault_code      <= BUS_RESET[6:5];
			can_fault_code      <= BUS_RESET[2:1];
			bus_supply_low_flag <= BUS_RESET[SUPPLY_LOW_BIT];
		end
		else
		begin
			if (lin_tsd_s || lin_txd_s || lin_bus_s)
				lin_fault_code <= fcode(lin_tsd_s, lin_txd_s, lin_bus_s);
			else if (clr_bus)
				lin_fault_code <= 2'h0;
			if (can_tsd_s || can_txd_s || can_bus_s)
				can_fault_code <= fcode(can_tsd_s, can_txd_s, can_bus_s);
			else if (clr_bus)
				can_fault_code <= 2'h0;
			bus_supply_low_flag <= sticky(bus_supply_low_flag, vcan_check, clr_bus);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			can_tx_disable <= 1'b0;
		else
			can_tx_disable <= vcan_check;
	end

	// =========================================
	// read path: data is the value before any clear
	// reserved bits zero
	logic [7:0] rd_mux;
	always_comb
	begin
		case (f_addr)
			ADDR_THERMAL_STATUS: rd_mux = {5'h00, therm_r};
			ADDR_DEVICE_STATUS:  rd_mux = {prior_state_code, 2'h0, wd_cnt_r,
				bad_cmd_r, fail_flag_r};
			ADDR_BUS_FAULT:      rd_mux = {1'b0, lin_fault_code, 2'h0,
				can_fault_code, bus_supply_low_flag};
			default:             rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end
		else
		begin
			rd_valid <= spi_valid && !spi_frame_bad;
			if (spi_valid && !spi_frame_bad)
				rd_data <= rd_mux;
		end
	end

	// =========================================
	// restart handling
	// restart keeps every status flag as it stands: the thermal flags,
	// the prior-state code, the count and the two device flags are all
	// updated only by their own events and by host clears
	// the reserved bits are constant zero in the read mux, so there is
	// nothing for restart to zero in storage
	// limitation: restart_pulse is accepted but not needed by any
	// register; it is kept on the port so the mode logic need not change
	// if a later register must react to restart
	logic unused_restart;
	assign unused_restart = restart_pulse;

	// =========================================
	// notes for integration
	// level inputs from the analog side, except ov_event, pass two flip-flops, so a
	// status flag appears three clocks after its cause; same-clock
	// strobes from the mode logic are taken in the cycle they stand
	// a clear frame and an event in one cycle leave the flag set, so
	// the host never loses an event that arrives during its clear
	// the read byte is taken before the clear, which lets the host read
	// and clear a register with one frame
endmodule

// ### verification/fsr_host.sv
`timescale 1ns/1ns
// ==========
// host side: one 16-bit frame per call
module fsr_host
(
	output logic		spi_valid,	// frame strobe
	output logic [15:0]	spi_frame,	// frame word
	output logic		spi_frame_bad,	// invalid frame
	input  wire logic	ref_clk		// logic clock
);
	initial
	begin
		spi_valid = 1'b0;
		spi_frame = 16'h0000;
		spi_frame_bad = 1'b0;
	end
	task automatic xfer(input logic [15:0] f, input logic b);
		@(posedge ref_clk);
		spi_valid <= 1'b1;
		spi_frame <= f;
		spi_frame_bad <= b;
		@(posedge ref_clk);
		spi_valid <= 1'b0;
		// idle word flips so a stale frame is never trusted
		spi_frame <= ~f;
	endtask
endmodule

// ### verification/fsr_checker.sv
`timescale 1ns/1ns
// ==========
// port assertions
module fsr_checker
	import fsr_pkg::*;
(
	input wire logic	ref_clk,	// clock
	input wire logic	rst,		// reset
	input wire logic	spi_valid,	// strobe
	input wire logic [15:0]	spi_frame,	// frame
	input wire logic	spi_frame_bad,	// invalid
	input wire logic	thermal_shutdown_second_flag_event,	// thermal_shutdown_second_flag
	input wire logic	wd_trigger_ok,	// trigger
	input wire logic	watchdog_failure_count_event,	// watchdog_failure_count
	input wire logic	can_mode_hi,	// mode
	input wire logic	can_supply_low,	// supply
	input wire logic	rd_valid,	// answer
	input wire logic [7:0]	rd_data,	// data
	input wire logic	failsafe_req,	// failsafe
	input wire logic	fail_output_pin,	// fail out
	input wire logic	can_tx_disable	// tx off
);
	logic [6:0]	addr_r;	// address rd_data answers
	always_ff @(posedge ref_clk)
		if (rst)
			addr_r <= 7'h00;
		else if (spi_valid && !spi_frame_bad)
			addr_r <= spi_frame[6:0];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_read_answered: assert property (spi_valid && !spi_frame_bad |=> rd_valid)
		else $error("read not answered");
	a_bad_refused: assert property (spi_valid && spi_frame_bad |=> !rd_valid)
		else $error("bad frame answered");
	a_data_held: assert property (!(spi_valid && !spi_frame_bad) |=> $stable(rd_data))
		else $error("read data moved");
	a_thermal_reserved: assert property (rd_valid && addr_r == ADDR_THERMAL_STATUS |->
		rd_data[7:3] == 5'h00) else $error("thermal reserved set");
	a_device_counter: assert property (rd_valid && addr_r == ADDR_DEVICE_STATUS |->
		rd_data[5:4] == 2'h0 && rd_data[3:2] != 2'h3) else $error("device bits bad");
	a_unmapped_zero: assert property (rd_valid && (addr_r < ADDR_THERMAL_STATUS ||
		addr_r > ADDR_BUS_FAULT) |-> rd_data == 8'h00) else $error("unmapped not zero");
	a_failsafe_forced: assert property (thermal_shutdown_second_flag_event [*3] |=> failsafe_req)
		else $error("no failsafe request");
	a_tx_disabled: assert property ((can_supply_low && can_mode_hi) [*3] |=> can_tx_disable)
		else $error("transmitter not off");
	a_tx_mode_gate: assert property (!can_mode_hi |=> !can_tx_disable)
		else $error("transmitter off outside mode");
	a_fail_pin_cleared: assert property (wd_trigger_ok && !watchdog_failure_count_event |=> !fail_output_pin)
		else $error("fail output stays");
endmodule
bind fsr_fault_status fsr_checker i_chk (
	.ref_clk, .rst, .spi_valid, .spi_frame, .spi_frame_bad, .thermal_shutdown_second_flag_event,
	.wd_trigger_ok, .watchdog_failure_count_event, .can_mode_hi, .can_supply_low, .rd_valid,
	.rd_data, .failsafe_req, .fail_output_pin, .can_tx_disable
);

// ### verification/fault_status_registers_tb.sv
`timescale 1ns/1ns
module fault_status_registers_tb
	import fsr_pkg::*;
;
	logic		ref_clk = 1'b0;
	logic		rst = 1'b1;
	logic		spi_valid, spi_frame_bad, rd_valid, fs, fo, tx;
	logic [15:0]	spi_frame;
	logic [7:0]	rd_data;
	logic [5:0]	pr = '0;
	logic [3:0]	wd = '0;
	logic [2:0]	th = '0, ln = '0, cn = '0, cfg = '0;
	logic		rs = 1'b0, ovs = 1'b0, mh = 1'b0, lo = 1'b0;
	int		err_total = 0, checks = 0, seed = 26989;
	always #5 ref_clk = ~ref_clk;
	fsr_host i_host (.ref_clk, .spi_valid, .spi_frame, .spi_frame_bad);
	fsr_fault_status i_dut (
		.ref_clk, .rst, .spi_valid, .spi_frame, .spi_frame_bad, .restart_pulse(rs),
		.thermal_shutdown_second_flag_event(th[2]), .thermal_shutdown_first_flag_event(th[1]), .tpw_event(th[0]), .watchdog_failure_count_event(wd[0]),
		.wd_trigger_ok(wd[1]), .wd_stopped(wd[2]), .wd_stop_by_fail(wd[3]),
		.cfg_select(cfg), .uv_event(pr[0]), .ov_event(pr[5]), .overvoltage_reset_select(ovs),
		.failsafe_wake(pr[1]), .illegal_sleep(pr[2]), .sleep_exit(pr[3]),
		.sleep_wake_pend(pr[4]), .lin_tsd(ln[0]), .lin_txd_dom(ln[1]), .lin_bus_dom(ln[2]),
		.can_tsd(cn[0]), .can_txd_dom(cn[1]), .can_bus_dom(cn[2]), .can_mode_hi(mh),
		.can_supply_low(lo), .rd_valid, .rd_data, .failsafe_req(fs), .fail_output_pin(fo),
		.can_tx_disable(tx)
	);
	function automatic int xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// random data byte: the device must ignore it
	task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] m, e);
		logic [7:0] d;
		d = 8'(xs());
		i_host.xfer({d, c, a}, 1'b0);
		#1;
		chk("rd_valid", {7'h00, rd_valid}, 8'h01);
		chk("rd_data", rd_data & m, e & m);
	endtask
	task automatic summarize();
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		cyc(20000);
		err_total++;
		summarize();
	end
	// ==========
	// scenarios
	initial
	begin
		cyc(5);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++)
			rd(ADDR_THERMAL_STATUS + 7'(a), 0, 8'hFF, 8'h00);
		th <= 3'h7;
		rs <= 1'b1;
		cyc(4);
		chk("failsafe_req", {7'h00, fs}, 8'h01);
		th <= 3'h1;
		rs <= 1'b0;
		cyc(4);
		rd(ADDR_THERMAL_STATUS, 0, 8'hFF, 8'h07);
		rd(ADDR_THERMAL_STATUS, 1, 8'hFF, 8'h07);
		rd(ADDR_THERMAL_STATUS, 0, 8'hFF, 8'h01);
		th <= 3'h0;
		cyc(4);
		rd(ADDR_THERMAL_STATUS, 1, 8'hFF, 8'h01);
		rd(ADDR_THERMAL_STATUS, 0, 8'hFF, 8'h00);
		rd(ADDR_DEVICE_STATUS, 1, 8'h00, 8'h00);
		i_host.xfer(16'h0043, 1'b1);
		#1;
		chk("rd_valid", {7'h00, rd_valid}, 8'h00);
		rd(ADDR_DEVICE_STATUS, 1, 8'hFF, 8'h02);
		rd(ADDR_DEVICE_STATUS, 0, 8'hFF, 8'h00);
		for (int i = 0; i < 7; i++)
		begin
			@(posedge ref_clk);
			pr <= 6'(1 << (i == 6 ? 5 : i));
			ovs <= (i == 6);
			cyc(4);
			pr <= 6'h00;
			cyc(4);
			rd(ADDR_DEVICE_STATUS, 1, 8'hC0, (i < 3 || i == 6) ? 8'h40 : (i < 5 ? 8'h80 : 8'h00));
		end
		for (int c = 0; c < 7; c++)
		begin
			@(posedge ref_clk);
			cfg <= 3'(c % 5);
			wd <= 4'h1;
			@(posedge ref_clk);
			wd <= (c == 5) ? 4'h4 : (c == 6 ? 4'hC : 4'h0);
			cyc(2);
			wd <= 4'h0;
			chk("fail_output_pin", {7'h00, fo}, {7'h00, c == 2});
			rd(ADDR_DEVICE_STATUS, 1, 8'h0F, c == 2 ? 8'h05 : (c == 5 ? 8'h00 : 8'h04));
			rd(ADDR_DEVICE_STATUS, 0, 8'h0F, c == 5 ? 8'h00 : 8'h04);
			wd <= 4'h2;
			cyc(2);
			wd <= 4'h0;
			rd(ADDR_DEVICE_STATUS, 1, 8'h0C, 8'h00);
			chk("fail_output_pin", {7'h00, fo}, 8'h00);
		end
		for (int i = 0; i < 3; i++)
		begin
			@(posedge ref_clk);
			ln <= 3'(1 << i);
			cn <= 3'(1 << i);
			lo <= 1'b1;
			mh <= (i == 1);
			cyc(4);
			chk("can_tx_disable", {7'h00, tx}, {7'h00, i == 1});
			ln <= 3'h0;
			cn <= 3'h0;
			lo <= 1'b0;
			cyc(4);
			rd(ADDR_BUS_FAULT, 1, 8'hFF, 8'((i + 1) << 5 | (i + 1) << 1 | (i == 1)));
			rd(ADDR_BUS_FAULT, 0, 8'hFF, 8'h00);
		end
		summarize();
	end
endmodule
